/* File: common/mcgr_defines.svh */
// Register offsets, field positions and reset values for the metering config block
`ifndef MCGR_DEFINES_SVH
`define MCGR_DEFINES_SVH
`define MCGR_IDX_COMP_MODE 16'he60e
`define MCGR_IDX_GAIN_SEL 16'he60f
`define MCGR_ANGLE_LSB 9
`define MCGR_ANGLE_MSB 10
`define MCGR_NOM_A_BIT 11
`define MCGR_NOM_B_BIT 12
`define MCGR_NOM_C_BIT 13
`define MCGR_FREQ_BIT 14
`define MCGR_GI_LSB 0
`define MCGR_GN_LSB 3
`define MCGR_GV_LSB 6
`define MCGR_COMP_RST 16'h0000
`define MCGR_GAIN_RST 16'h0000
`define MCGR_COMP_WMASK 16'h7e00
`define MCGR_GAIN_WMASK 16'h01ff
`define MCGR_GAIN_WMASK_NO_N 16'h01c7
`endif

/* File: common/mcgr_pkg.sv */
// Types for the metering config block
package mcgr_pkg;
    typedef enum logic [1:0] {
        MCGR_ANG_VI = 2'h0,
        MCGR_ANG_VV = 2'h1,
        MCGR_ANG_II = 2'h2,
        MCGR_ANG_OFF = 2'h3
    } mcgr_angle_t;
    typedef struct packed {
        logic meas_vi;
        logic meas_vv;
        logic meas_ii;
        logic [2:0] nominal_volt_use;
        logic line_frequency_select;
    } mcgr_mode_t;
    typedef struct packed {
        logic [4:0] phase_current_gain;
        logic [4:0] neutral_current_gain;
        logic [4:0] phase_voltage_gain;
    } mcgr_gain_t;
endpackage

/* File: hw/mcgr_regs.sv */
// APB register bank for metering computation mode and gain selection
//
// Overview of operation
// - Code 10 currents angles, 11 none
// - Code 00 volt-current, 01 voltage angles
// - Bit 11 substitutes nominal voltage phase A
// - Bit 12 substitutes nominal voltage phase B
// - Bit 13 substitutes nominal voltage phase C
// - Nominal enables reset zero, measured voltage used
// - Mode bit 15 zero, no function
// - Current gain codes 000-100 give 1-16
// - Current gain reserved codes mean unity
// - Neutral gain same encoding, default 000
// - Neutral gain reserved codes mean unity
// - No neutral channel keeps field 000
// - Voltage gain codes 000-100 give 1-16
// - Voltage gain reserved codes mean unity
// - Gain bits 15:9 zero, no function
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "mcgr_defines.svh"
module mcgr_regs
    import mcgr_pkg::*;
#(
    parameter bit HAS_NEUTRAL = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [23:0] nominal_voltage_value,
    input wire logic [23:0] meas_vrms_a,
    input wire logic [23:0] meas_vrms_b,
    input wire logic [23:0] meas_vrms_c,
    output logic [23:0] vrms_a_used,
    output logic [23:0] vrms_b_used,
    output logic [23:0] vrms_c_used,
    output mcgr_mode_t mode_out,
    output mcgr_gain_t gain_out
);
    localparam logic [31:0] ADDR_COMP = {14'h0000, `MCGR_IDX_COMP_MODE, 2'h0};
    localparam logic [31:0] ADDR_GAIN = {14'h0000, `MCGR_IDX_GAIN_SEL, 2'h0};
    localparam logic [15:0] GAIN_WMASK = HAS_NEUTRAL ? `MCGR_GAIN_WMASK : `MCGR_GAIN_WMASK_NO_N;

    logic [15:0] comp_reg;
    logic [15:0] comp_next;
    logic [15:0] gain_reg;
    logic [15:0] gain_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic err_reg;
    logic err_next;
    logic [23:0] va_reg;
    logic [23:0] va_next;
    logic [23:0] vb_reg;
    logic [23:0] vb_next;
    logic [23:0] vc_reg;
    logic [23:0] vc_next;
    mcgr_mode_t mode_reg;
    mcgr_mode_t mode_next;
    mcgr_gain_t gain_dec_reg;
    mcgr_gain_t gain_dec_next;

    logic setup;
    logic access;
    logic hit_comp;
    logic hit_gain;
    logic [15:0] wmask16;
    logic [15:0] wdata16;
    mcgr_angle_t angle;

    // Decode a 3-bit code to a one-hot shift of 1..16, reserved codes give unity
    function automatic logic [4:0] gain_decode(input logic [2:0] code);
        logic [4:0] g;
        g = 5'h01;
        unique case (code)
            3'h0: g = 5'h01;
            3'h1: g = 5'h02;
            3'h2: g = 5'h04;
            3'h3: g = 5'h08;
            3'h4: g = 5'h10;
            default: g = 5'h01;
        endcase
        return g;
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign hit_comp = (paddr == ADDR_COMP);
    assign hit_gain = (paddr == ADDR_GAIN);
    assign wmask16 = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata16 = pwdata[15:0];
    assign angle = mcgr_angle_t'(comp_reg[`MCGR_ANGLE_MSB:`MCGR_ANGLE_LSB]);

    // Read capture and decode error in setup, writes land at the completing access edge
    always_comb begin
        comp_next = comp_reg;
        gain_next = gain_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup) begin
            err_next = !(hit_comp || hit_gain);
            rdata_next = 32'h0000_0000;
            if (!pwrite) begin
                if (hit_comp) begin
                    rdata_next = {16'h0000, comp_reg};
                end
                if (hit_gain) begin
                    rdata_next = {16'h0000, gain_reg};
                end
            end
        end
        if (access && pwrite) begin
            if (hit_comp) begin
                comp_next = ((comp_reg & ~wmask16) | (wdata16 & wmask16))
                            & `MCGR_COMP_WMASK;
            end
            if (hit_gain) begin
                gain_next = ((gain_reg & ~wmask16) | (wdata16 & wmask16))
                            & GAIN_WMASK;
            end
        end
    end

    // Decoded settings and voltage substitution for the datapath
    always_comb begin
        mode_next.meas_vi = (angle == MCGR_ANG_VI);
        mode_next.meas_vv = (angle == MCGR_ANG_VV);
        mode_next.meas_ii = (angle == MCGR_ANG_II);
        mode_next.nominal_volt_use = {comp_reg[`MCGR_NOM_C_BIT], comp_reg[`MCGR_NOM_B_BIT],
                                      comp_reg[`MCGR_NOM_A_BIT]};
        mode_next.line_frequency_select = comp_reg[`MCGR_FREQ_BIT];
        va_next = comp_reg[`MCGR_NOM_A_BIT] ? nominal_voltage_value : meas_vrms_a;
        vb_next = comp_reg[`MCGR_NOM_B_BIT] ? nominal_voltage_value : meas_vrms_b;
        vc_next = comp_reg[`MCGR_NOM_C_BIT] ? nominal_voltage_value : meas_vrms_c;
        gain_dec_next.phase_current_gain =
            gain_decode(gain_reg[`MCGR_GI_LSB +: 3]);
        gain_dec_next.neutral_current_gain =
            gain_decode(gain_reg[`MCGR_GN_LSB +: 3]);
        gain_dec_next.phase_voltage_gain =
            gain_decode(gain_reg[`MCGR_GV_LSB +: 3]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_reg <= `MCGR_COMP_RST;
            gain_reg <= `MCGR_GAIN_RST;
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            va_reg <= 24'h000000;
            vb_reg <= 24'h000000;
            vc_reg <= 24'h000000;
            mode_reg <= '{meas_vi: 1'b1, default: '0};
            gain_dec_reg <= '{5'h01, 5'h01, 5'h01};
        end else begin
            comp_reg <= comp_next;
            gain_reg <= gain_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            va_reg <= va_next;
            vb_reg <= vb_next;
            vc_reg <= vc_next;
            mode_reg <= mode_next;
            gain_dec_reg <= gain_dec_next;
        end
    end

    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = psel && penable && err_reg;
    assign vrms_a_used = va_reg;
    assign vrms_b_used = vb_reg;
    assign vrms_c_used = vc_reg;
    assign mode_out = mode_reg;
    assign gain_out = gain_dec_reg;
endmodule // mcgr_regs

/* File: sim/mcgr_regs_chk.sv */
// Assertion checker for the metering config register bank
`timescale 1ns/1ps
module mcgr_regs_chk
    import mcgr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input logic [31:0] prdata,
    input mcgr_mode_t mode_out,
    input mcgr_gain_t gain_out
);
    wire rd = psel && penable && !pwrite;
    wire rd_c = rd && paddr == 32'h00039838;
    wire rd_g = rd && paddr == 32'h0003983c;
    function automatic logic [4:0] dec(input logic [2:0] c);
        return (c > 3'h4) ? 5'h01 : 5'h01 << c;
    endfunction
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ANG_VV:
        assert property (rd_c |-> mode_out.meas_vi == (prdata[10:9] == 2'h0)
            && mode_out.meas_vv == (prdata[10:9] == 2'h1)) else $error("angle flags");
    AST_ANG_II:
        assert property (rd_c |-> mode_out.meas_ii == (prdata[10:9] == 2'h2)) else $error("ii");
    AST_NOM:
        assert property (rd_c |-> mode_out.nominal_volt_use == prdata[13:11]) else $error("nom");
    AST_RSV_C:
        assert property (rd_c |-> prdata[31:15] == 17'h0 && prdata[8:0] == 9'h0) else $error("rc");
    AST_GI:
        assert property (rd_g |-> gain_out.phase_current_gain == dec(prdata[2:0])) else $error("gi");
    AST_GN:
        assert property (rd_g |-> gain_out.neutral_current_gain == dec(prdata[5:3])) else $error("gn");
    AST_GV:
        assert property (rd_g |-> gain_out.phase_voltage_gain == dec(prdata[8:6])) else $error("gv");
    AST_FREQ:
        assert property (rd_c |-> mode_out.line_frequency_select == prdata[14]) else $error("fq");
    AST_RSV_G:
        assert property (rd_g |-> prdata[31:9] == 23'h0) else $error("rg");
endmodule // mcgr_regs_chk
bind mcgr_regs mcgr_regs_chk u_mcgr_regs_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .mode_out, .gain_out);

/* File: sim/tb_top.sv */
// Self-checking bench for the metering config register bank
`timescale 1ns/1ps
module tb_top;
    import mcgr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, a;
    logic [23:0] va, vb, vc;
    mcgr_mode_t mode_out;
    mcgr_gain_t gain_out;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    logic [32:0] rows [14] = '{33'h0ffff7e00, 33'h002000200, 33'h004000400, 33'h006000600,
        33'h040004000, 33'h1ffff01ff, 33'h100490049, 33'h100920092, 33'h100db00db,
        33'h101240124, 33'h1016d016d, 33'h101b601b6, 33'h000000000, 33'h100000000};
    mcgr_regs u_mcgr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .nominal_voltage_value(24'h0000aa),
        .meas_vrms_a(24'h000001), .meas_vrms_b(24'h000002), .meas_vrms_c(24'h000003),
        .vrms_a_used(va), .vrms_b_used(vb), .vrms_c_used(vc), .mode_out, .gain_out);
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] ad, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            a = rows[i][32] ? 32'h0003983c : 32'h00039838;
            apb(1'b1, a, rows[i][31:16]);
            apb(1'b0, a, 16'h0000);
            chk(72'(rd), 72'(rows[i][15:0]));
        end
        apb(1'b1, 32'h00039838, 16'h2800);
        repeat (2) @(negedge pclk);
        chk({va, vb, vc}, {24'haa, 24'h2, 24'haa});
        apb(1'b1, 32'h00039840, 16'hffff);
        apb(1'b0, 32'h00039840, 16'h0000);
        chk(72'({er, rd}), 72'({1'b1, 32'h0}));
        apb(1'b0, 32'h00039838, 16'h0000);
        chk(72'(rd), 72'h2800);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 32'h00039838, 16'h0000);
        chk(72'(rd), 72'h0);
        @(negedge pclk);
        chk({va, vb, vc}, {24'h1, 24'h2, 24'h3});
        chk(72'({mode_out, gain_out}), 72'h200421);
        end_sim();
    end
endmodule // tb_top
